// >>> hw/dlyi2c_pkg.sv
// Contract
// (R1) Answer to 7-bit address with fixed upper five bits, base 0x38.
// (R2) High strap gives address bit 1, low strap bit 0: 0x38..0x3B.
// (R3) System ties both straps to a defined level; never floating.
// (R4) Drive data line only for acknowledge or read data; else release.
// (R5) Data output open drain: pull low only, never drive high.
// (R6) First byte is address plus direction; compare against strap address.
// (R7) Write: address, color select, delay code stored into selected register.
// (R8) Read: address, color select, address again, then stored code returned.
// (R9) Third byte of read repeats address; device then transmits stored code.
// (R10) Color bits 00 red, 01 green, 10 blue; direction bit picks read/write.
// (R11) Registers hold 6-bit code in low six data bits; upper two ignored.
// (R12) Interface active only powered up, digital control, two-wire bus chosen.
// (R13) Mismatched address: no acknowledge, line released, transaction ignored.
// (R14) Master repeats start before read address, not-acknowledges code, then stops.
package dlyi2c_pkg;
  localparam logic [4:0] DEV_ADDR_BASE = 5'h0E; // Upper five bits of 0x38
  localparam int CODE_W = 6;
  localparam logic [1:0] SEL_RED = 2'h0;
  localparam logic [1:0] SEL_GREEN = 2'h1;
  localparam logic [1:0] SEL_BLUE = 2'h2;
  localparam logic [CODE_W-1:0] CODE_RESET = 6'h00;
  localparam logic [3:0] BIT_LAST = 4'h7;
  localparam logic [3:0] BIT_ACK = 4'h8;
  typedef enum {ST_IDLE, ST_ADDR, ST_SEL, ST_DATA, ST_TX, ST_SKIP} dlyi2c_state_t;
endpackage

// >>> hw/dlyi2c_sync.sv
`timescale 1ns/10ps
`default_nettype none
// Two-flop synchroniser; first stage read only by second
module dlyi2c_sync (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic asyncIn,
  output logic syncOut
);
  logic meta_r;
  logic meta_nxt;
  logic sync_nxt;
  // Stage values
  always_comb begin
    meta_nxt = asyncIn;
    sync_nxt = meta_r;
  end
  // Reset high: idle bus level
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      meta_r <= 1'b1;
      syncOut <= 1'b1;
    end else begin
      meta_r <= meta_nxt;
      syncOut <= sync_nxt;
    end
  end
endmodule // dlyi2c_sync
`default_nettype wire

// >>> hw/dlyi2c_slave.sv
`timescale 1ns/10ps
`default_nettype none
// Two-wire target holding three delay codes
module dlyi2c_slave (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic sclIn,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  input wire logic addr_strap_high,
  input wire logic addr_strap_low,
  input wire logic power_down_n,
  input wire logic modeAnalog,
  input wire logic bus_type_select,
  output logic [dlyi2c_pkg::CODE_W-1:0] redCode,
  output logic [dlyi2c_pkg::CODE_W-1:0] greenCode,
  output logic [dlyi2c_pkg::CODE_W-1:0] blueCode
);
  import dlyi2c_pkg::*;

  logic sclS, sdaS, pdS, modeS, busS, strapHiS, strapLoS;
  logic sclD_r, sdaD_r, sclD_nxt, sdaD_nxt;
  dlyi2c_state_t state_r, state_nxt;
  logic [3:0] bitCnt_r, bitCnt_nxt;
  logic [7:0] shift_r, shift_nxt;
  logic [1:0] sel_r, sel_nxt;
  logic rdPhase_r, rdPhase_nxt;
  logic drvLow_r, drvLow_nxt;
  logic waitFall_r, waitFall_nxt;
  logic [CODE_W-1:0] red_r, green_r, blue_r, red_nxt, green_nxt, blue_nxt;
  logic sclRise, sclFall, startCond, stopCond, active, addrHit;
  logic [6:0] ownAddr;
  logic [CODE_W-1:0] selCode;
  logic [7:0] txByte;

  // Pins pass two flops before any logic looks at them
  dlyi2c_sync uSyncScl (.sys_clk(sys_clk), .rst_n(rst_n), .asyncIn(sclIn), .syncOut(sclS));
  dlyi2c_sync uSyncSda (.sys_clk(sys_clk), .rst_n(rst_n), .asyncIn(sdaIn), .syncOut(sdaS));
  dlyi2c_sync uSyncPd (.sys_clk(sys_clk), .rst_n(rst_n), .asyncIn(power_down_n), .syncOut(pdS));
  dlyi2c_sync uSyncMode (.sys_clk(sys_clk), .rst_n(rst_n), .asyncIn(modeAnalog), .syncOut(modeS));
  dlyi2c_sync uSyncBus (.sys_clk(sys_clk), .rst_n(rst_n), .asyncIn(bus_type_select), .syncOut(busS));
  dlyi2c_sync uSyncAh (.sys_clk(sys_clk), .rst_n(rst_n), .asyncIn(addr_strap_high), .syncOut(strapHiS));
  dlyi2c_sync uSyncAl (.sys_clk(sys_clk), .rst_n(rst_n), .asyncIn(addr_strap_low), .syncOut(strapLoS));

  // Bus events and address match; straps assumed tied, never floating (R3)
  always_comb begin
    sclD_nxt = sclS;
    sdaD_nxt = sdaS;
    sclRise = sclS && !sclD_r;
    sclFall = !sclS && sclD_r;
    startCond = sclS && sclD_r && !sdaS && sdaD_r;
    stopCond = sclS && sclD_r && sdaS && !sdaD_r;
    active = pdS && !modeS && !busS; // R12
    ownAddr = {DEV_ADDR_BASE, strapHiS, strapLoS}; // R1 R2
    addrHit = (shift_r[7:1] == ownAddr); // R6
    case (sel_r) // R10
      SEL_RED: selCode = red_r;
      SEL_GREEN: selCode = green_r;
      SEL_BLUE: selCode = blue_r;
      default: selCode = CODE_RESET;
    endcase
    // Read-back byte: two zero pad bits above the code (R11)
    txByte = {2'h0, selCode};
  end

  // Protocol engine; bit count 0..7 data, 8 is acknowledge slot
  always_comb begin
    state_nxt = state_r;
    bitCnt_nxt = bitCnt_r;
    shift_nxt = shift_r;
    sel_nxt = sel_r;
    rdPhase_nxt = rdPhase_r;
    drvLow_nxt = drvLow_r;
    red_nxt = red_r;
    green_nxt = green_r;
    blue_nxt = blue_r;
    if (!active) begin
      state_nxt = ST_IDLE; // R12
      drvLow_nxt = 1'b0;
    end else if (startCond) begin
      // Repeated start keeps rdPhase so the resent address reads (R14)
      state_nxt = ST_ADDR;
      bitCnt_nxt = 4'h0;
      drvLow_nxt = 1'b0;
      rdPhase_nxt = (state_r == ST_DATA || state_r == ST_ADDR) && rdPhase_r;
    end else if (stopCond) begin
      state_nxt = ST_IDLE;
      drvLow_nxt = 1'b0;
      rdPhase_nxt = 1'b0;
    end else if (state_r == ST_TX) begin
      // MSB first; the line is pulled only for zero bits
      if (sclFall) begin
        if (bitCnt_r < BIT_LAST) begin
          bitCnt_nxt = bitCnt_r + 4'h1;
          drvLow_nxt = !shift_r[6]; // R4 R5
          shift_nxt = {shift_r[6:0], 1'b0};
        end else if (bitCnt_r == BIT_LAST) begin
          bitCnt_nxt = BIT_ACK;
          drvLow_nxt = 1'b0; // Master's acknowledge slot
        end else begin
          state_nxt = ST_SKIP; // Single code byte; then wait for stop (R14)
        end
      end
    end else if (state_r == ST_ADDR || state_r == ST_SEL || state_r == ST_DATA) begin
      if (sclRise && bitCnt_r <= BIT_LAST) begin
        shift_nxt = {shift_r[6:0], sdaS};
      end
      // The fall that closes a start carries no bit
      if (sclFall && !waitFall_r) begin
        if (bitCnt_r < BIT_LAST) begin
          bitCnt_nxt = bitCnt_r + 4'h1;
        end else if (bitCnt_r == BIT_LAST) begin
          bitCnt_nxt = BIT_ACK;
          if (state_r != ST_ADDR || addrHit) begin
            drvLow_nxt = 1'b1; // R4
          end else begin
            state_nxt = ST_SKIP; // R13
          end
        end else begin
          drvLow_nxt = 1'b0;
          bitCnt_nxt = 4'h0;
          case (state_r)
            ST_ADDR: begin
              if (shift_r[0] && rdPhase_r) begin
                state_nxt = ST_TX; // R8 R9
                // First bit out is the byte's MSB, a pad zero
                drvLow_nxt = !txByte[7];
                shift_nxt = txByte;
              end else if (shift_r[0]) begin
                state_nxt = ST_SKIP;
              end else begin
                state_nxt = ST_SEL;
              end
            end
            ST_SEL: begin
              // Select kept for the write or the read that follows
              sel_nxt = shift_r[1:0]; // R10
              rdPhase_nxt = 1'b1;
              state_nxt = ST_DATA;
            end
            ST_DATA: begin
              case (sel_r) // R7 R11
                SEL_RED: red_nxt = shift_r[CODE_W-1:0];
                SEL_GREEN: green_nxt = shift_r[CODE_W-1:0];
                SEL_BLUE: blue_nxt = shift_r[CODE_W-1:0];
                default: ;
              endcase
              rdPhase_nxt = 1'b0;
              state_nxt = ST_SKIP;
            end
            default: state_nxt = ST_SKIP;
          endcase
        end
      end
    end
  end

  // Skip the SCL fall right after a start, else every address bit lands one slot early (R6)
  always_comb begin
    waitFall_nxt = waitFall_r;
    if (!active || stopCond) begin
      waitFall_nxt = 1'b0;
    end else if (startCond) begin
      waitFall_nxt = 1'b1;
    end else if (sclFall) begin
      waitFall_nxt = 1'b0;
    end
  end

  // Start guard register
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      waitFall_r <= 1'b0;
    end else begin
      waitFall_r <= waitFall_nxt;
    end
  end

  // Registers
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      sclD_r <= 1'b1;
      sdaD_r <= 1'b1;
      state_r <= ST_IDLE;
      bitCnt_r <= 4'h0;
      shift_r <= 8'h00;
      sel_r <= SEL_RED;
      rdPhase_r <= 1'b0;
      drvLow_r <= 1'b0;
      red_r <= CODE_RESET;
      green_r <= CODE_RESET;
      blue_r <= CODE_RESET;
    end else begin
      sclD_r <= sclD_nxt;
      sdaD_r <= sdaD_nxt;
      state_r <= state_nxt;
      bitCnt_r <= bitCnt_nxt;
      shift_r <= shift_nxt;
      sel_r <= sel_nxt;
      rdPhase_r <= rdPhase_nxt;
      drvLow_r <= drvLow_nxt;
      red_r <= red_nxt;
      green_r <= green_nxt;
      blue_r <= blue_nxt;
    end
  end

  // Open drain: output always low, only the enable moves (R5)
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      sdaOut <= 1'b0;
      sdaOe <= 1'b0;
      redCode <= CODE_RESET;
      greenCode <= CODE_RESET;
      blueCode <= CODE_RESET;
    end else begin
      sdaOut <= 1'b0; // R5
      sdaOe <= drvLow_nxt; // R4
      redCode <= red_nxt;
      greenCode <= green_nxt;
      blueCode <= blue_nxt;
    end
  end
endmodule // dlyi2c_slave
`default_nettype wire

// >>> bench/dlyi2c_asserts.sv
`timescale 1ns/10ps
`default_nettype none
// Pin-level watch on the target
module dlyi2c_asserts (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic sclIn,
  input wire logic sdaOut,
  input wire logic sdaOe,
  input wire logic power_down_n,
  input wire logic modeAnalog,
  input wire logic bus_type_select,
  input wire logic [dlyi2c_pkg::CODE_W-1:0] redCode,
  input wire logic [dlyi2c_pkg::CODE_W-1:0] greenCode,
  input wire logic [dlyi2c_pkg::CODE_W-1:0] blueCode
);
  import dlyi2c_pkg::*;
  wire logic act = power_down_n && !modeAnalog && !bus_type_select;
  wire logic [17:0] codes = {redCode, greenCode, blueCode};
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // Pin moves only in the SCL low phase, else a false start or stop appears
  chk_out_low: assert property (sdaOut == 1'b0) else $error("data driven high");
  chk_rst_clear: assert property ($rose(rst_n) |-> !sdaOe && codes == {3{CODE_RESET}}) else $error("reset");
  chk_oe_rise: assert property ($rose(sdaOe) |-> !sclIn) else $error("pull while SCL high");
  chk_oe_fall: assert property ($fell(sdaOe) |-> !sclIn) else $error("release while SCL high");
  chk_oe_hold: assert property (sclIn && $past(sclIn) |-> $stable(sdaOe)) else $error("moved in high");
  chk_idle_release: assert property (!act [*3] |-> !sdaOe) else $error("driven while off");
  chk_idle_codes: assert property (!act [*3] |=> $stable(codes)) else $error("code moved while off");
  chk_code_update: assert property ($changed(codes) |-> !sclIn) else $error("code moved in high");
endmodule // dlyi2c_asserts
`default_nettype wire

// >>> bench/dlyi2c_master.sv
`timescale 1ns/10ps
`default_nettype none
// Bus master; SCL rests high between frames, data moves only while SCL is low except at start and stop
module dlyi2c_master (
  input wire logic sys_clk,
  input wire logic sdaIn,
  output logic scl,
  output logic sdaPull
);
  logic busy;
  initial begin
    scl = 1'b1;
    sdaPull = 1'b0;
    busy = 1'b0;
  end
  // Quarter of the 80 ns bit
  task automatic step(input logic p, input logic c);
    sdaPull <= p;
    scl <= c;
    repeat (4) @(posedge sys_clk);
  endtask
  // Start when s is high, stop when low
  // SCL stays still on an idle bus; only a running frame needs the low-high lead-in
  task automatic frame(input logic s);
    if (busy) begin
      step(sdaPull, 1'b0);
      step(!s, 1'b0);
      step(!s, 1'b1);
    end
    step(s, 1'b1);
    if (s) step(1'b1, 1'b0);
    busy = s;
  endtask
  // Nine clocks MSB first; bit 0 is the acknowledge slot
  task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
    for (int i = 8; i >= 0; i--) begin
      step(sdaPull, 1'b0);
      step(!tx[i], 1'b0);
      step(!tx[i], 1'b1);
      rx[i] = sdaIn;
      step(!tx[i], 1'b1);
    end
  endtask
endmodule // dlyi2c_master
`default_nettype wire

// >>> bench/testbench.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(e, g) begin checks_done++; if ((g) !== (e)) begin bad_count++; $display("Error %0t %h %h", $time, e, g); end end
bind dlyi2c_slave dlyi2c_asserts chk_u (.sys_clk, .rst_n, .sclIn, .sdaOut, .sdaOe, .power_down_n, .modeAnalog,
  .bus_type_select, .redCode, .greenCode, .blueCode);
// Target against a master model; results compared in order with noted expectations
module testbench;
  import dlyi2c_pkg::*;
  logic sys_clk = 1'b0, rst_n = 1'b0, hi = 1'b0, lo = 1'b0, pwrN = 1'b1, modeAnalog = 1'b0, busSel = 1'b0;
  logic scl, sdaPull, sdaOe, sdaOut, nw, nr, resStb = 1'b0;
  logic [CODE_W-1:0] redCode, greenCode, blueCode;
  logic [CODE_W-1:0] mdl [3] = '{default: 6'h00};
  logic [26:0] expQ[$], resVal, expV;
  logic [8:0] r0, r1, r2, r3;
  logic [7:0] d;
  logic [6:0] a;
  int bad_count = 0, checks_done = 0, seed = 50;
  wire logic sda = (sdaOe ? sdaOut : 1'b1) & !sdaPull; // Pull-up wins when nobody pulls
  dlyi2c_slave dut_u (.sys_clk, .rst_n, .sclIn(scl), .sdaIn(sda), .sdaOut, .sdaOe, .addr_strap_high(hi),
    .addr_strap_low(lo), .power_down_n(pwrN), .modeAnalog, .bus_type_select(busSel), .redCode, .greenCode, .blueCode);
  dlyi2c_master m_u (.sys_clk, .sdaIn(sda), .scl, .sdaPull);
  initial forever #2.5 sys_clk = ~sys_clk;
  // Write: address, select, code
  task automatic wr(input logic [1:0] s);
    m_u.frame(1'b1);
    m_u.xfer({a, 2'b01}, r0);
    m_u.xfer({6'h00, s, 1'b1}, r1);
    m_u.xfer({d, 1'b1}, r2);
    m_u.frame(1'b0);
    nw = r0[0] | r1[0] | r2[0];
  endtask
  // Read with repeated start; master refuses the returned byte
  task automatic rd(input logic [1:0] s);
    m_u.frame(1'b1);
    m_u.xfer({a, 2'b01}, r0);
    m_u.xfer({6'h00, s, 1'b1}, r1);
    m_u.frame(1'b1);
    m_u.xfer({a, 2'b11}, r2);
    m_u.xfer(9'h1FF, r3);
    m_u.frame(1'b0);
    nr = r0[0] | r1[0] | r2[0];
  endtask
  // Note expectation, show result one cycle
  task automatic note(input logic [26:0] e, input logic [26:0] g);
    expQ.push_back(e);
    resVal <= g;
    resStb <= 1'b1;
    @(posedge sys_clk);
    resStb <= 1'b0;
  endtask
  always @(posedge sys_clk) begin
    if (resStb === 1'b1) begin
      expV = expQ.pop_front();
      `CHK(expV, resVal)
    end
  end
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (6) @(posedge sys_clk);
    // Each strap pair and colour; upper data bits random
    for (int k = 0; k < 12; k++) begin
      {hi, lo} <= 2'(k / 3);
      a = {DEV_ADDR_BASE, 2'(k / 3)};
      d = 8'($random(seed));
      mdl[k % 3] = d[5:0];
      wr(2'(k % 3));
      rd(2'(k % 3));
      note({3'b000, d[5:0], mdl[0], mdl[1], mdl[2]}, {nw | nr, r3[8:1], redCode, greenCode, blueCode});
    end
    // Unused select value: acknowledged, stores nothing, reads back zero
    a = {DEV_ADDR_BASE, hi, lo};
    d = 8'($random(seed));
    wr(2'h3);
    rd(2'h3);
    note({3'b000, 6'h00, mdl[0], mdl[1], mdl[2]}, {nw | nr, r3[8:1], redCode, greenCode, blueCode});
    $display("access test done");
    // Foreign address, other strap, then each inactive mode
    for (int k = 0; k < 5; k++) begin
      {pwrN, modeAnalog, busSel} <= {k != 2, k == 3, k == 4};
      a = (k == 0) ? 7'h3C : {DEV_ADDR_BASE, hi ^ (k == 1), lo};
      d = 8'($random(seed));
      wr(2'(k % 3));
      note({9'h100, mdl[0], mdl[1], mdl[2]}, {nw, 8'h00, redCode, greenCode, blueCode});
    end
    $display("refusal test done");
    end_of_test();
  end
  initial begin
    repeat (90000) @(posedge sys_clk);
    bad_count++;
    end_of_test();
  end
endmodule // testbench
`default_nettype wire
